// >>> logic/parsq_pkg.sv
/*
  package for the pixel array readout sequencer: array geometry, timing
  constants and the carrier structs of the sequencer.
  assumes a single 100 MHz clock and no software-reachable registers.
*/
package parsq_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int unsigned COLS         = 1280;
  localparam int unsigned ROWS         = 1024;
  localparam int unsigned NUM_OUTPUTS  = 16;
  localparam int unsigned COL_GROUPS   = COLS / NUM_OUTPUTS;
  localparam int unsigned X_W          = 7;
  localparam int unsigned Y_W          = 10;
  localparam int unsigned PIX_W        = 8;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_PS           = 10000;
  localparam int unsigned FRAME_OVERHEAD_TIME_NS  = 1000;
  localparam int unsigned ROW_BLANKING_TIME_NS    = 200;
  localparam int unsigned FOT_CYCLES = (FRAME_OVERHEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
  localparam int unsigned RBT_CYCLES = (ROW_BLANKING_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
  localparam int unsigned CNT_W      = 8;
  localparam logic [X_W-1:0] X_RESET = 7'h00;
  localparam logic [Y_W-1:0] Y_RESET = 10'h000;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic             x_sync;
    logic             x_clk;
    logic             y_sync;
    logic             y_clk;
  } parsq_scan_type;

  typedef struct packed {
    logic [X_W-1:0]   x_start;
    logic [Y_W-1:0]   y_start;
  } parsq_window_type;

  typedef struct packed {
    logic             reset;
    logic             precharge;
    logic             sample;
  } parsq_shutter_type;

  typedef enum logic [2:0] {
    PH_OVERHEAD = 3'b001,
    PH_BLANK    = 3'b010,
    PH_PIXELS   = 3'b100
  } parsq_phase_type;

endpackage : parsq_pkg

// >>> logic/parsq_sequencer.sv
/*
  readout and shutter sequencer inside the sensor: x and y pointers, both-edge
  column clock decode, global reset/precharge/sample, frame timing counters.
  assumes the camera controller drives clocks, syncs and shutter pulses as
  asynchronous pins; each pin is slow compared to the 100 MHz clock.
*/
// Notes on behaviour
// - both edges of the column clock are active; pixel period is half clock period.
// - each frame carries a fixed 1 us frame overhead before its lines; an x sync or y clock rise ends it early.
// - each line opens with nominally 200 ns row blanking, which may be shortened.
// - frame period is overhead plus lines times (blanking plus pixels/16 periods).
// - window is scanned line by line, then column by column, via x and y pointers.
// - start column and start row are programmed independently through configuration.
// - a sync pulse reloads that pointer with its programmed start address.
// - an active clock edge (either x edge, rising y edge) advances only its own pointer by one position.
// - whole core resets at once, then all pixels sample together at integration end.
// - after the global sample, stored values are read out line by line.
// - next frame integration may run during readout of the current frame.
// - non-destructive mode resets once and reads many times without further resets.
// - sixteen outputs each present one new level at every active column edge.
// - precharge clears pixel memory, then sample moves photodiode value into it.
`timescale 1ns/100ps

module parsq_sequencer (
  // clock and reset
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_i,
  // controller pins
  input  wire parsq_pkg::parsq_scan_type              scan_i,
  input  wire parsq_pkg::parsq_shutter_type           shutter_i,
  input  wire logic                                   nondestructive_readout_mode_i,
  // configuration download
  input  wire parsq_pkg::parsq_window_type            window_i,
  input  wire logic                                   window_load_i,
  // photodiode levels of the addressed 16-pixel group
  input  wire logic [parsq_pkg::NUM_OUTPUTS*parsq_pkg::PIX_W-1:0] diode_i,
  // pointers, pixel data and status
  output logic [parsq_pkg::X_W-1:0]                   x_ptr_o,
  output logic [parsq_pkg::Y_W-1:0]                   y_ptr_o,
  output logic [parsq_pkg::NUM_OUTPUTS*parsq_pkg::PIX_W-1:0] pix_o,
  output logic                                        pix_valid_o,
  output logic                                        core_reset_o,
  output logic                                        mem_clear_o,
  output logic                                        mem_sample_o,
  output logic                                        row_blank_o,
  output logic                                        frame_overhead_o,
  output logic                                        readout_armed_o
);

  localparam int unsigned PW = parsq_pkg::NUM_OUTPUTS * parsq_pkg::PIX_W;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [2:0]                  s_xs;
    logic [2:0]                  s_xc;
    logic [2:0]                  s_ys;
    logic [2:0]                  s_yc;
    logic [2:0]                  s_rs;
    logic [2:0]                  s_pc;
    logic [2:0]                  s_sm;
    parsq_pkg::parsq_window_type win;
    logic [parsq_pkg::X_W-1:0]   x_ptr;
    logic [parsq_pkg::Y_W-1:0]   y_ptr;
    logic [PW-1:0]               mem;
    logic [PW-1:0]               pix;
    logic                        pix_valid;
    logic                        core_reset;
    logic                        mem_clear;
    logic                        mem_sample;
    logic                        reset_seen;
    logic                        armed;
    parsq_pkg::parsq_phase_type  phase;
    logic [parsq_pkg::CNT_W-1:0] cnt;
  } parsq_state_type;

  parsq_state_type r;
  parsq_state_type next_r;

  logic xs_rise;
  logic xc_edge;
  logic ys_rise;
  logic yc_rise;
  logic rs_lvl;
  logic pc_lvl;
  logic sm_fall;

  // ************************************************************
  // pin decode: a change counts when stage two differs from stage three
  // ************************************************************
  always_comb begin
    // stage one is never read here: it may still be settling
    xs_rise = r.s_xs[1] & ~r.s_xs[2];
    xc_edge = r.s_xc[1] ^ r.s_xc[2];
    ys_rise = r.s_ys[1] & ~r.s_ys[2];
    yc_rise = r.s_yc[1] & ~r.s_yc[2];
    rs_lvl  = r.s_rs[2];
    pc_lvl  = r.s_pc[2];
    sm_fall = ~r.s_sm[1] & r.s_sm[2];
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_r      = r;

    // ************************************************************
    // synchronizer chains
    // ************************************************************
    next_r.s_xs = {r.s_xs[1:0], scan_i.x_sync};
    next_r.s_xc = {r.s_xc[1:0], scan_i.x_clk};
    next_r.s_ys = {r.s_ys[1:0], scan_i.y_sync};
    next_r.s_yc = {r.s_yc[1:0], scan_i.y_clk};
    next_r.s_rs = {r.s_rs[1:0], shutter_i.reset};
    next_r.s_pc = {r.s_pc[1:0], shutter_i.precharge};
    next_r.s_sm = {r.s_sm[1:0], shutter_i.sample};
    next_r.pix_valid = 1'b0;

    // ************************************************************
    // configuration and global shutter
    // ************************************************************
    if (window_load_i) begin
      next_r.win = window_i;
    end

    // global shutter; non-destructive mode lets only one reset through per sequence
    next_r.core_reset = rs_lvl & ~(nondestructive_readout_mode_i & r.reset_seen);
    // a passed reset is remembered only as it ends, so it stands for its full length;
    // with the mode low every reset passes
    if (r.core_reset & ~rs_lvl & nondestructive_readout_mode_i) begin
      next_r.reset_seen = 1'b1;
    end else if (!nondestructive_readout_mode_i) begin
      next_r.reset_seen = 1'b0;
    end
    next_r.mem_clear  = pc_lvl;
    next_r.mem_sample = r.s_sm[2];
    if (pc_lvl) begin
      next_r.mem = '0;
    end else if (r.s_sm[2]) begin
      next_r.mem = diode_i;
    end
    // integration end arms the readout of that frame; integration goes on meanwhile
    if (sm_fall) begin
      next_r.armed = 1'b1;
    end

    // ************************************************************
    // y pointer and frame timers
    // ************************************************************
    // y pointer: sync reloads, clock steps one line
    if (ys_rise) begin
      next_r.y_ptr = r.win.y_start;
      next_r.phase = parsq_pkg::PH_OVERHEAD;
      next_r.cnt   = parsq_pkg::CNT_W'(parsq_pkg::FOT_CYCLES - 1);
    end else if (yc_rise) begin
      next_r.y_ptr = r.y_ptr + parsq_pkg::Y_W'(1);
      next_r.phase = parsq_pkg::PH_BLANK;
      next_r.cnt   = parsq_pkg::CNT_W'(parsq_pkg::RBT_CYCLES - 1);
    end else if (r.cnt != '0) begin
      next_r.cnt = r.cnt - parsq_pkg::CNT_W'(1);
    end

    // ************************************************************
    // x pointer and pixel output
    // ************************************************************
    // x pointer: an x sync ends blanking early, which shortens it
    if (xs_rise) begin
      next_r.x_ptr = r.win.x_start;
      next_r.phase = parsq_pkg::PH_PIXELS;
      next_r.cnt   = '0;
    end else if (xc_edge) begin
      next_r.x_ptr     = r.x_ptr + parsq_pkg::X_W'(1);
      next_r.pix       = r.mem;
      next_r.pix_valid = r.armed;
    end

    // ************************************************************
    // phase end
    // ************************************************************
    // timers ending leave the overhead or blanking phase idle in pixel phase
    if (!xs_rise && !ys_rise && !yc_rise && r.cnt == '0 &&
        r.phase != parsq_pkg::PH_PIXELS) begin
      next_r.phase = parsq_pkg::PH_PIXELS;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r            <= '0;
      r.x_ptr      <= parsq_pkg::X_RESET;
      r.y_ptr      <= parsq_pkg::Y_RESET;
      r.phase      <= parsq_pkg::PH_PIXELS;
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    x_ptr_o          = r.x_ptr;
    y_ptr_o          = r.y_ptr;
    pix_o            = r.pix;
    pix_valid_o      = r.pix_valid;
    core_reset_o     = r.core_reset;
    mem_clear_o      = r.mem_clear;
    mem_sample_o     = r.mem_sample;
    // one-hot phase bits feed the status pins with no decode gate
    row_blank_o      = r.phase[1];
    frame_overhead_o = r.phase[0];
    readout_armed_o  = r.armed;
  end

endmodule // parsq_sequencer

// >>> tb/parsq_ctl_model.sv
/* camera controller model driving the scan and shutter pins.
   assumes callers enter its tasks just after a rising clock edge. */
`timescale 1ns/100ps
module parsq_ctl_model (
  // clock
  input  wire logic                   clk_i,
  // controller pins
  output parsq_pkg::parsq_scan_type    scan_o,
  output parsq_pkg::parsq_shutter_type shutter_o
);
  initial begin
    scan_o    = '0;
    shutter_o = '0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // levels stand 4 cycles or more, since the pin synchronizer may drop shorter ones
  task automatic pulse_scan(input int b);
    @(posedge clk_i) scan_o[b] <= 1'b1;
    hold(4);
    scan_o[b] <= 1'b0;
    hold(6);
  endtask
  task automatic edge_x();
    @(posedge clk_i) scan_o.x_clk <= ~scan_o.x_clk;
    hold(5);
  endtask
  task automatic pulse_shut(input int b);
    @(posedge clk_i) shutter_o[b] <= 1'b1;
    hold(4);
    shutter_o[b] <= 1'b0;
    hold(6);
  endtask
endmodule // parsq_ctl_model

// >>> tb/parsq_seq_assertions.sv
/* checker for the readout sequencer, watching its ports only.
   assumes it is bound into the sequencer from the bench top file. */
`timescale 1ns/100ps
module parsq_seq_assertions (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire parsq_pkg::parsq_scan_type    scan_i,
  input wire parsq_pkg::parsq_shutter_type shutter_i,
  input wire parsq_pkg::parsq_window_type  window_i,
  input wire logic [parsq_pkg::X_W-1:0]    x_ptr_o,
  input wire logic [parsq_pkg::Y_W-1:0]    y_ptr_o,
  input wire logic                         pix_valid_o,
  input wire logic                         mem_clear_o,
  input wire logic                         mem_sample_o,
  input wire logic                         row_blank_o,
  input wire logic                         frame_overhead_o,
  input wire logic                         readout_armed_o
);
  logic [7:0] fot_run;
  logic [7:0] blank_run;
  // run lengths of the two phase levels, cleared whenever the level drops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fot_run   <= 8'h00;
      blank_run <= 8'h00;
    end else begin
      fot_run   <= frame_overhead_o ? fot_run + 8'h01 : 8'h00;
      blank_run <= row_blank_o ? blank_run + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_valid_single: assert property (pix_valid_o |=> !pix_valid_o)
    else $error("pix_valid_o held over one cycle");
  chk_valid_step: assert property (pix_valid_o |-> x_ptr_o == $past(x_ptr_o) + 7'h01)
    else $error("column edge did not advance x pointer by one");
  chk_valid_row: assert property (pix_valid_o |-> $stable(y_ptr_o))
    else $error("column edge moved the row pointer");
  chk_valid_armed: assert property (pix_valid_o |-> readout_armed_o)
    else $error("pixel data before any sample");
  chk_armed_hold: assert property (readout_armed_o |=> readout_armed_o)
    else $error("readout_armed_o dropped");
  chk_armed_cause: assert property ($fell(mem_sample_o) |-> ##[0:2] readout_armed_o)
    else $error("sample end did not arm readout");
  chk_clear_follow: assert property ($rose(shutter_i.precharge) |-> ##[2:4] mem_clear_o)
    else $error("precharge not passed to memory clear");
  chk_sample_follow: assert property ($rose(shutter_i.sample) |-> ##[2:4] mem_sample_o)
    else $error("sample pin not passed to memory sample");
  chk_xsync_load: assert property ($rose(scan_i.x_sync) |-> ##[2:4] x_ptr_o == window_i.x_start)
    else $error("x sync did not load start column");
  chk_ysync_load: assert property ($rose(scan_i.y_sync) |-> ##[2:4] y_ptr_o == window_i.y_start)
    else $error("y sync did not load start row");
  chk_fot_len: assert property ($fell(frame_overhead_o) |-> fot_run == 8'h64)
    else $error("frame overhead not 100 cycles");
  chk_blank_max: assert property (row_blank_o |-> blank_run < 8'h14)
    else $error("row blanking over 20 cycles");
  cover property (pix_valid_o);
  cover property ($fell(frame_overhead_o));
  cover property ($rose(readout_armed_o));
endmodule // parsq_seq_assertions

// >>> tb/parsq_sequencer_tb.sv
/* self-checking bench for the readout sequencer with a controller model.
   assumes the package, sequencer, checker and model are compiled first. */
`timescale 1ns/100ps
module parsq_sequencer_tb;
  localparam int PW = parsq_pkg::NUM_OUTPUTS * parsq_pkg::PIX_W;
  logic clk_i;
  logic rst_i;
  logic nondestructive_readout_mode_i;
  logic window_load_i;
  parsq_pkg::parsq_window_type window_i;
  parsq_pkg::parsq_scan_type scan_i;
  parsq_pkg::parsq_shutter_type shutter_i;
  logic [PW-1:0] diode_i;
  logic [PW-1:0] pix_o;
  logic [parsq_pkg::X_W-1:0] x_ptr_o;
  logic [parsq_pkg::Y_W-1:0] y_ptr_o;
  logic pix_valid_o, core_reset_o, mem_clear_o, mem_sample_o;
  logic row_blank_o, frame_overhead_o, readout_armed_o;
  int mismatches = 0, tests_run = 0, cycles = 0;
  int n_valid = 0, n_reset = 0, n_clear = 0, n_sample = 0, n_blank = 0, n_fot = 0;
  parsq_sequencer dut (.clk_i, .rst_i, .scan_i, .shutter_i, .nondestructive_readout_mode_i,
    .window_i, .window_load_i, .diode_i, .x_ptr_o, .y_ptr_o, .pix_o, .pix_valid_o,
    .core_reset_o, .mem_clear_o, .mem_sample_o, .row_blank_o, .frame_overhead_o,
    .readout_armed_o);
  parsq_ctl_model ctl (.clk_i, .scan_o(scan_i), .shutter_o(shutter_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // level counters use non-blocking updates so readers see one fixed edge
  always @(posedge clk_i) begin
    cycles   <= cycles + 1;
    n_valid  <= n_valid + pix_valid_o;
    n_reset  <= n_reset + core_reset_o;
    n_clear  <= n_clear + mem_clear_o;
    n_sample <= n_sample + mem_sample_o;
    n_blank  <= n_blank + row_blank_o;
    n_fot    <= n_fot + frame_overhead_o;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [PW-1:0] seen, input logic [PW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic t_shutter();
    int c = n_clear;
    int s = n_sample;
    ctl.pulse_shut(1);
    check("mem_clear", n_clear > c, 1'b1);
    @(posedge clk_i) diode_i <= {16{8'h5a}};
    ctl.pulse_shut(0);
    check("mem_sample", n_sample > s, 1'b1);
    check("armed", readout_armed_o, 1'b1);
  endtask
  task automatic t_frame();
    int f = n_fot;
    int b;
    @(posedge clk_i) begin
      window_i      <= {7'h05, 10'h003};
      window_load_i <= 1'b1;
    end
    @(posedge clk_i) window_load_i <= 1'b0;
    ctl.pulse_scan(1);
    ctl.hold(100);
    check("fot", n_fot - f, 100);
    check("y_start", y_ptr_o, 10'h003);
    for (int i = 0; i < 2; i++) begin
      b = n_blank;
      ctl.pulse_scan(0);
      ctl.hold(i ? 0 : 20);
      ctl.pulse_scan(3);
      check("blank", (n_blank - b) == 20, i == 0);
      check("y_step", y_ptr_o, 10'h004 + i);
      check("x_start", x_ptr_o, 7'h05);
    end
  endtask
  task automatic t_columns();
    int v = n_valid;
    for (int i = 1; i <= 4; i++) begin
      ctl.edge_x();
      check("x_ptr", x_ptr_o, 7'h05 + i);
      check("pix", pix_o, {16{8'h5a}});
    end
    check("valids", n_valid - v, 4);
    check("y_hold", y_ptr_o, 10'h005);
  endtask
  task automatic t_ndr();
    int r;
    @(posedge clk_i) nondestructive_readout_mode_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (i == 2) @(posedge clk_i) nondestructive_readout_mode_i <= 1'b0;
      r = n_reset;
      ctl.pulse_shut(2);
      check("core_reset", n_reset > r, i != 1);
    end
    ctl.edge_x();
    check("x_during_int", x_ptr_o, 7'h0a);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst_i                         <= 1'b1;
    nondestructive_readout_mode_i <= 1'b0;
    window_load_i                 <= 1'b0;
    window_i                      <= '0;
    diode_i                       <= '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_shutter();
    t_frame();
    t_columns();
    t_ndr();
    summarize();
  end
endmodule // parsq_sequencer_tb
bind parsq_sequencer parsq_seq_assertions chk (.clk_i, .rst_i, .scan_i, .shutter_i, .window_i,
  .x_ptr_o, .y_ptr_o, .pix_valid_o, .mem_clear_o, .mem_sample_o, .row_blank_o,
  .frame_overhead_o, .readout_armed_o);
